// ---- hw/qbs_defs.svh ----
// Contract
// - Write beats are captured on true-clock and inverted-clock rising edges.
// - Narrow variant uses data bits 0-17 only; wide variant uses 0-35.
// - Echo clock pair toggles continuously, even while read data floats.
// - Read bus driven only after read commands, beats on input clock edges.
// - Read-valid rises half cycle before first beat, falls half cycle early.
// - Write select low loads address; beats for offset 0 then 1 follow.
// - Read select low at t loads address; beats output from t+2.
// - Selects are sampled only at the true-clock rising edge.
// - Data outputs float from power-up until a read is issued.
// - Stopped input clocks hold burst state; a pending fetch and the bypass flag still update on clk.
// - Read wins over a simultaneous write; running bursts may overlap.
// - Burst address gets an internal low bit, offset 0 then 1, two beats.
// - Active-low lane mask, sampled with its beat, enables each 9-bit byte.
// - Bypass input low bypasses the internal PLL.
`ifndef QBS_DEFS_SVH
`define QBS_DEFS_SVH

`define QBS_DATA_W      36
`define QBS_NARROW_W    18
`define QBS_ADDR_W      22
`define QBS_ROW_W       22
`define QBS_LANES       4
`define QBS_LANE_W      9
`define QBS_NARROW_LANES 2

`endif

// ---- hw/qbs_pkg.sv ----
`default_nettype none
`include "qbs_defs.svh"

package qbs_pkg;

    typedef logic [`QBS_DATA_W-1:0]  qbs_data_t;
    typedef logic [`QBS_ADDR_W-1:0]  qbs_addr_t;
    typedef logic [`QBS_ROW_W-1:0]   qbs_row_t;
    typedef logic [`QBS_LANES-1:0]   qbs_lane_t;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_ADDR0,
        RD_ADDR1,
        RD_LAST
    } qbs_fetch_t;

    typedef struct packed {
        logic      k;
        logic      k_n;
        logic      rd_n;
        logic      wr_n;
        logic      pll_bypass_n;
        qbs_addr_t addr;
        qbs_data_t d;
        qbs_lane_t lane_mask_n;
    } qbs_pins_t;

    typedef struct packed {
        qbs_pins_t  s1;
        qbs_pins_t  s2;
        logic       k_d;
        logic       kn_d;
        logic       echo_t;
        logic       echo_i;
        logic       bypass;
        logic       p1;
        logic       p2;
        qbs_addr_t  ra;
        qbs_addr_t  rb;
        qbs_fetch_t fetch;
        qbs_data_t  buf0;
        qbs_data_t  buf1;
        qbs_data_t  q;
        qbs_data_t  qh;
        logic       q_oe_n;
        logic       beat1_pend;
        logic       valid;
        logic       wbeat1;
        qbs_addr_t  wa;
        logic       wr_req;
        qbs_row_t   wr_row;
        qbs_data_t  wr_data;
        qbs_lane_t  wr_lane;
    } qbs_state_t;

endpackage : qbs_pkg

`default_nettype wire

// ---- hw/qbs_mem_if.sv ----
`default_nettype none
`include "qbs_defs.svh"

interface qbs_mem_if;
    logic                    we;
    logic [`QBS_ROW_W-1:0]   waddr;
    logic [`QBS_DATA_W-1:0]  wdata;
    logic [`QBS_LANES-1:0]   wlane;
    logic [`QBS_ROW_W-1:0]   raddr;
    logic [`QBS_DATA_W-1:0]  rdata;

    modport ctrl (output we, output waddr, output wdata, output wlane,
                  output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input wlane,
                  input raddr, output rdata);
endinterface : qbs_mem_if

`default_nettype wire

// ---- hw/qbs_mem.sv ----
`default_nettype none
`include "qbs_defs.svh"

module qbs_mem (
    input  wire logic clk,
    qbs_mem_if.mem    port
);
    import qbs_pkg::*;

    logic [`QBS_DATA_W-1:0] ram [0:(1<<`QBS_ROW_W)-1];
    logic [`QBS_DATA_W-1:0] rdata;

    // Per-lane write enables, registered read data
    always_ff @(posedge clk) begin
        for (int i = 0; i < `QBS_LANES; i++) begin
            if (port.we && port.wlane[i]) begin
                ram[port.waddr][i*`QBS_LANE_W +: `QBS_LANE_W] <=
                    port.wdata[i*`QBS_LANE_W +: `QBS_LANE_W];
            end
        end
        rdata <= ram[port.raddr];
    end

    assign port.rdata = rdata;

endmodule // qbs_mem

`default_nettype wire

// ---- hw/qbs_port.sv ----
`default_nettype none
`include "qbs_defs.svh"

module qbs_port #(
    parameter bit WIDE = 1'b1
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               k,
    input  wire logic               k_n,
    input  wire logic               rd_n,
    input  wire logic               wr_n,
    input  wire logic               pll_bypass_n,
    input  wire qbs_pkg::qbs_addr_t burst_base_address,
    input  wire qbs_pkg::qbs_data_t d,
    input  wire qbs_pkg::qbs_lane_t lane_mask_n,
    output logic                    echo_timing_true,
    output logic                    echo_timing_inverted,
    output logic                    read_valid_flag,
    output qbs_pkg::qbs_data_t      q,
    output logic                    q_oe_n,
    output logic                    pll_bypass_active
);
    import qbs_pkg::*;

    localparam qbs_state_t RST_STATE = '{
        s1: '0, s2: '0, k_d: 1'b0, kn_d: 1'b0, echo_t: 1'b0, echo_i: 1'b0,
        bypass: 1'b0, p1: 1'b0, p2: 1'b0, ra: '0, rb: '0, fetch: RD_IDLE,
        buf0: '0, buf1: '0, q: '0, qh: '0, q_oe_n: 1'b1, beat1_pend: 1'b0,
        valid: 1'b0, wbeat1: 1'b0, wa: '0, wr_req: 1'b0, wr_row: '0,
        wr_data: '0, wr_lane: '0
    };

    qbs_state_t st;
    qbs_state_t next_st;
    qbs_pins_t  pins;
    logic       k_rise;
    logic       kn_rise;
    logic       rd_go;
    logic       wr_go;

    qbs_mem_if mem_bus ();

    qbs_mem u_mem (
        .clk  (clk),
        .port (mem_bus.mem)
    );

    // Memory row of a beat; narrow keeps two beats in one row halves
    function automatic qbs_row_t row_of(input qbs_addr_t base, input logic beat);
        if (WIDE)
            row_of = {base[`QBS_ADDR_W-2:0], beat};
        else
            row_of = base;
    endfunction

    function automatic qbs_data_t wdata_of(input qbs_data_t din, input logic beat);
        if (WIDE)
            wdata_of = din;
        else if (beat)
            wdata_of = {din[`QBS_NARROW_W-1:0], `QBS_NARROW_W'h0};
        else
            wdata_of = {`QBS_NARROW_W'h0, din[`QBS_NARROW_W-1:0]};
    endfunction

    function automatic qbs_lane_t lane_of(input qbs_lane_t mask_n, input logic beat);
        logic [`QBS_NARROW_LANES-1:0] m;
        m = ~mask_n[`QBS_NARROW_LANES-1:0];
        if (WIDE)
            lane_of = ~mask_n;
        else if (beat)
            lane_of = {m, 2'h0};
        else
            lane_of = {2'h0, m};
    endfunction

    function automatic qbs_data_t rdata_of(input qbs_data_t r, input logic beat);
        if (WIDE)
            rdata_of = r;
        else if (beat)
            rdata_of = {`QBS_NARROW_W'h0, r[`QBS_DATA_W-1:`QBS_NARROW_W]};
        else
            rdata_of = {`QBS_NARROW_W'h0, r[`QBS_NARROW_W-1:0]};
    endfunction

    always_comb begin
        pins.k            = k;
        pins.k_n          = k_n;
        pins.rd_n         = rd_n;
        pins.wr_n         = wr_n;
        pins.pll_bypass_n = pll_bypass_n;
        pins.addr         = burst_base_address;
        pins.d            = d;
        pins.lane_mask_n  = lane_mask_n;
    end

    // Pin edges after the two-stage synchroniser
    assign k_rise  = st.s2.k & ~st.k_d;
    assign kn_rise = st.s2.k_n & ~st.kn_d;
    assign rd_go   = k_rise & ~st.s2.rd_n;
    assign wr_go   = k_rise & st.s2.rd_n & ~st.s2.wr_n;

    always_comb begin
        next_st        = st;
        next_st.s1     = pins;
        next_st.s2     = st.s1;
        next_st.k_d    = st.s2.k;
        next_st.kn_d   = st.s2.k_n;
        next_st.echo_t = st.s2.k;
        next_st.echo_i = st.s2.k_n;
        next_st.bypass = ~st.s2.pll_bypass_n;
        next_st.wr_req = 1'b0;

        // Edges advance the burst state; the fetch steps and the write strobe clears on clk alone
        if (k_rise) begin
            next_st.p1 = rd_go;
            next_st.p2 = st.p1;
            if (rd_go) begin
                next_st.ra = st.s2.addr;
            end
            if (st.p1) begin
                next_st.rb    = st.ra;
                next_st.fetch = RD_ADDR0;
            end
            if (st.p2) begin
                next_st.q          = st.buf0;
                next_st.qh         = st.buf1;
                next_st.q_oe_n     = 1'b0;
                next_st.beat1_pend = 1'b1;
            end else begin
                next_st.q_oe_n     = 1'b1;
                next_st.beat1_pend = 1'b0;
            end
            if (wr_go) begin
                next_st.wr_req  = 1'b1;
                next_st.wr_row  = row_of(st.s2.addr, 1'b0);
                next_st.wr_data = wdata_of(st.s2.d, 1'b0);
                next_st.wr_lane = lane_of(st.s2.lane_mask_n, 1'b0);
                next_st.wa      = st.s2.addr;
                next_st.wbeat1  = 1'b1;
            end
        end

        if (kn_rise) begin
            next_st.valid = st.p2;
            if (st.beat1_pend) begin
                next_st.q          = st.qh;
                next_st.beat1_pend = 1'b0;
            end
            if (st.wbeat1) begin
                next_st.wr_req  = 1'b1;
                next_st.wr_row  = row_of(st.wa, 1'b1);
                next_st.wr_data = wdata_of(st.s2.d, 1'b1);
                next_st.wr_lane = lane_of(st.s2.lane_mask_n, 1'b1);
                next_st.wbeat1  = 1'b0;
            end
        end

        // Fetch both beats well ahead of the output edge
        case (st.fetch)
            RD_IDLE: begin
            end
            RD_ADDR0: begin
                next_st.fetch = RD_ADDR1;
            end
            RD_ADDR1: begin
                next_st.buf0  = rdata_of(mem_bus.rdata, 1'b0);
                next_st.fetch = RD_LAST;
            end
            RD_LAST: begin
                next_st.buf1  = rdata_of(mem_bus.rdata, 1'b1);
                next_st.fetch = RD_IDLE;
            end
            default: begin
                next_st.fetch = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Synchronisers keep tracking the pins, so no false edge follows reset
            st      <= RST_STATE;
            st.s1   <= next_st.s1;
            st.s2   <= next_st.s2;
            st.k_d  <= next_st.k_d;
            st.kn_d <= next_st.kn_d;
        end else begin
            st <= next_st;
        end
    end

    assign mem_bus.we    = st.wr_req;
    assign mem_bus.waddr = st.wr_row;
    assign mem_bus.wdata = st.wr_data;
    assign mem_bus.wlane = st.wr_lane;
    assign mem_bus.raddr = row_of(st.rb, st.fetch == RD_ADDR1);

    assign echo_timing_true     = st.echo_t;
    assign echo_timing_inverted = st.echo_i;
    assign read_valid_flag      = st.valid;
    assign q                    = st.q;
    assign q_oe_n               = st.q_oe_n;
    assign pll_bypass_active    = st.bypass;

endmodule // qbs_port

`default_nettype wire

// ---- test/qbs_port_monitor.sv ----
`default_nettype none
module qbs_port_monitor (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               k,
    input wire logic               k_n,
    input wire logic               pll_bypass_n,
    input wire logic               echo_timing_true,
    input wire logic               echo_timing_inverted,
    input wire logic               read_valid_flag,
    input wire qbs_pkg::qbs_data_t q,
    input wire logic               q_oe_n,
    input wire logic               pll_bypass_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import qbs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ECHO_T: assert property ($rose(k) |-> ##[1:5] $rose(echo_timing_true))
        else $error("echo true late");
    AST_ECHO_I: assert property ($rose(k_n) |-> ##[1:5] $rose(echo_timing_inverted))
        else $error("echo inverted late");
    AST_BYP: assert property ($fell(pll_bypass_n) |-> ##[1:5] pll_bypass_active)
        else $error("bypass not active");
    AST_VLD_LEAD: assert property ($rose(read_valid_flag) |-> q_oe_n && $rose(echo_timing_inverted))
        else $error("valid lead wrong");
    AST_OE_FOLLOW: assert property ($rose(echo_timing_true) |-> (q_oe_n == !$past(read_valid_flag)))
        else $error("bus enable not led by valid");
    AST_VLD_TAIL: assert property ($fell(read_valid_flag) |-> !q_oe_n)
        else $error("valid fell late");
    AST_VLD_EDGE: assert property ($changed(read_valid_flag) |-> $changed(echo_timing_true))
        else $error("valid off echo");
    AST_Q_EDGE: assert property ($changed(q) |-> $changed(echo_timing_true))
        else $error("q off echo");
    AST_OE_EDGE: assert property ($changed(q_oe_n) |-> $changed(echo_timing_true))
        else $error("enable off echo");
    AST_OE_CAUSE: assert property ($fell(q_oe_n) |-> $past(read_valid_flag))
        else $error("q driven without read");
endmodule // qbs_port_monitor

bind qbs_port qbs_port_monitor i_qbs_port_monitor (
    .clk(clk), .rst_n(rst_n), .k(k), .k_n(k_n), .pll_bypass_n(pll_bypass_n),
    .echo_timing_true(echo_timing_true), .echo_timing_inverted(echo_timing_inverted),
    .read_valid_flag(read_valid_flag), .q(q), .q_oe_n(q_oe_n),
    .pll_bypass_active(pll_bypass_active));
`default_nettype wire

// ---- test/qbs_ctrl_model.sv ----
`default_nettype none
module qbs_ctrl_model #(
    // 125 link periods of 160 ns cover the 20 us setup
    parameter int SETUP_CYC = 125
) (
    input  wire logic          clk,
    output logic               k,
    output logic               k_n,
    output logic               rd_n,
    output logic               wr_n,
    output logic               pll_bypass_n,
    output qbs_pkg::qbs_addr_t burst_base_address,
    output qbs_pkg::qbs_data_t d,
    output qbs_pkg::qbs_lane_t lane_mask_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import qbs_pkg::*;
    initial begin
        {k, k_n, rd_n, wr_n} = 4'h7;
        pll_bypass_n = 1'b0;
        burst_base_address = '0;
        d = '0;
        lane_mask_n = 4'hF;
    end
    // Quarter link period
    task automatic wt();
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic kcyc(input logic r, input logic w, input qbs_addr_t a,
                        input qbs_data_t d0, input qbs_data_t d1,
                        input qbs_lane_t m0, input qbs_lane_t m1);
        rd_n = r;
        wr_n = w;
        burst_base_address = a;
        d = d0;
        lane_mask_n = m0;
        wt();
        {k, k_n} = 2'h2;
        wt();
        {rd_n, wr_n} = 2'h3;
        burst_base_address = ~a;
        d = d1;
        lane_mask_n = m1;
        wt();
        {k, k_n} = 2'h1;
        wt();
    endtask
    task automatic setup(input logic byp_n);
        pll_bypass_n = byp_n;
        repeat (SETUP_CYC) kcyc(1'b1, 1'b1, '0, '0, '0, 4'hF, 4'hF);
    endtask
    // Bypass level change with clocks parked; PLL never runs below its floor
    task automatic park_bypass(input logic byp_n);
        pll_bypass_n = byp_n;
        halt(8);
    endtask
    // Clocks parked at opposite levels
    task automatic halt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule // qbs_ctrl_model
`default_nettype wire

// ---- test/qbs_port_tb.sv ----
`default_nettype none
module qbs_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import qbs_pkg::*;
    localparam qbs_addr_t A_BASE = 22'h1ABCD0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic k, k_n, rd_n, wr_n, byp_n, echo_t, echo_i, vld, oe_n, byp_act;
    qbs_addr_t   a;
    qbs_data_t   d, q, q_nr;
    logic        vld_nr, oe_nr;
    logic [36:0] e;
    qbs_lane_t   m;
    qbs_data_t   mdl [4][2];
    logic [36:0] exp_q [$];
    int          n_fail = 0;
    int          tests_run = 0;
    logic        prev_rd = 1'b0;
    logic        echo_p = 1'b0;
    always #4 clk = ~clk;
    qbs_ctrl_model i_qbs_ctrl_model (.clk(clk), .k(k), .k_n(k_n), .rd_n(rd_n), .wr_n(wr_n),
        .pll_bypass_n(byp_n), .burst_base_address(a), .d(d), .lane_mask_n(m));
    qbs_port #(.WIDE(1'b1)) i_qbs_port (.clk(clk), .rst_n(rst_n), .k(k), .k_n(k_n),
        .rd_n(rd_n), .wr_n(wr_n), .pll_bypass_n(byp_n), .burst_base_address(a), .d(d),
        .lane_mask_n(m), .echo_timing_true(echo_t), .echo_timing_inverted(echo_i),
        .read_valid_flag(vld), .q(q), .q_oe_n(oe_n), .pll_bypass_active(byp_act));
    qbs_port #(.WIDE(1'b0)) i_qbs_port_narrow (.clk(clk), .rst_n(rst_n), .k(k), .k_n(k_n),
        .rd_n(rd_n), .wr_n(wr_n), .pll_bypass_n(byp_n), .burst_base_address(a), .d(d),
        .lane_mask_n(m), .echo_timing_true(), .echo_timing_inverted(),
        .read_valid_flag(vld_nr), .q(q_nr), .q_oe_n(oe_nr), .pll_bypass_active());
    task automatic chk(input logic [36:0] seen, input logic [36:0] want);
        tests_run++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic op(input logic r, input logic w, input int i, input logic rnd);
        logic [63:0] x0, x1;
        qbs_lane_t   m0, m1;
        x0 = {$urandom, $urandom};
        x1 = {$urandom, $urandom};
        m0 = rnd ? qbs_lane_t'($urandom) : 4'h0;
        m1 = rnd ? qbs_lane_t'($urandom) : 4'h0;
        if (!r) begin
            if (prev_rd) exp_q[$][36] = 1'b1;
            exp_q.push_back({1'b1, mdl[i][0]});
            exp_q.push_back({1'b0, mdl[i][1]});
        end else if (!w) begin
            for (int l = 0; l < 4; l++) begin
                if (!m0[l]) mdl[i][0][l*9+:9] = x0[l*9+:9];
                if (!m1[l]) mdl[i][1][l*9+:9] = x1[l*9+:9];
            end
        end
        prev_rd = ~r;
        i_qbs_ctrl_model.kcyc(r, w, A_BASE | qbs_addr_t'(i), x0[35:0], x1[35:0], m0, m1);
    endtask
    // Each echo edge with the bus driven carries one beat
    always @(negedge clk) begin
        if (rst_n && echo_t !== echo_p && oe_n === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk({vld, q}, 37'hX);
            end else begin
                e = exp_q.pop_front();
                chk({vld, q}, e);
                chk({vld_nr, q_nr}, {e[36], 18'h0, e[17:0]});
                chk({36'h0, oe_nr}, 37'h0);
            end
        end
        echo_p = echo_t;
    end
    initial begin
        repeat (100000) @(posedge clk);
        chk(37'h0, 37'h1);
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'h7CAC));
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        i_qbs_ctrl_model.setup(1'b0);
        chk({vld, 35'h0, oe_n}, 37'h1);
        chk({36'h0, byp_act}, 37'h1);
        for (int i = 0; i < 4; i++) op(1'b1, 1'b0, i, 1'b0);
        for (int i = 0; i < 4; i++) op(1'b0, 1'b1, i, 1'b0);
        for (int n = 0; n < 80; n++) begin
            op(1'($urandom), 1'($urandom), int'($urandom % 4), 1'b1);
            if (n == 40) i_qbs_ctrl_model.halt(200);
        end
        i_qbs_ctrl_model.park_bypass(1'b1);
        chk({36'h0, byp_act}, 37'h0);
        i_qbs_ctrl_model.setup(1'b0);
        prev_rd = 1'b0;
        chk({36'h0, byp_act}, 37'h1);
        for (int i = 0; i < 4; i++) op(1'b0, 1'b0, i, 1'b0);
        repeat (4) op(1'b1, 1'b1, 0, 1'b1);
        chk({vld, 35'h0, oe_n}, 37'h1);
        // Read back: data offered during idle cycles must not be stored
        op(1'b0, 1'b1, 0, 1'b0);
        repeat (3) op(1'b1, 1'b1, 1, 1'b0);
        chk(37'(exp_q.size()), 37'h0);
        tally_and_finish();
    end
endmodule // qbs_port_tb
`default_nettype wire
